// ---- hw/lmio_top.sv ----
// How it works
// - Pedal is active low; press accepted after 100 ms of steady low.
// - Accepted pedal press acts as start/pause: start, suspend, resume.
// - A press starting under 100 ms after the previous press is ignored.
// - Door guard has an enable; when disabled its input is not looked at.
// - Enabled door guard high or floating suspends work and kills laser.
// - Manual fire low turns lasers on; high or open leaves them to work_running and laser_req.
// - Each limit has a polarity bit; default low means at limit, LED lit.
// - Minus limit is the zero end of travel, plus limit the maximum end.
// - Four axes X, Y, Z, U, each with one direction and one step output.
// - Each axis direction output has a selectable polarity.
// - Homing steps an axis toward origin until its minus limit trips.
// - Step active edge selectable falling or rising; falling after reset.
// - Two laser channels, each with enable, PWM and coolant guard input.
// - RF type leaves enable idle; glass tube uses enable, active low.
// - Channel PWM drives RF modulation or tube power-setting input.
// - Enabled coolant guard high kills both lasers, suspends work, warns.
// - Disabled coolant guard input is not monitored and may float.
`timescale 1ns/1ps
module lmio_top #(
  parameter int PEDAL_CYCLES = lmio_pkg::PEDAL_CYC,
  parameter int HOME_DIV = lmio_pkg::HOME_DIV_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pedal_in,
  input wire logic door_guard_in,
  input wire logic fire_in,
  input wire logic spare_in,
  input wire logic [3:0] axis_min_limit,
  input wire logic [3:0] axis_max_limit,
  input wire logic [1:0] coolant_guard_in,
  input wire logic [3:0] step_req,
  input wire logic [3:0] step_dir,
  input wire logic [1:0] laser_req,
  output logic [3:0] axis_dir_out,
  output logic [3:0] axis_step_out,
  output logic [1:0] laser_enable_out_n,
  output logic [1:0] laser_power_pwm,
  output logic [7:0] limit_led,
  output logic [1:0] coolant_warn,
  output logic work_running,
  output logic work_suspended
);
  import lmio_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronizers
  // ----------------------------------------------------------------
  localparam int NIN = 14;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;
  logic pedal_s, door_s, fire_s, spare_s;
  logic [3:0] min_s, max_s;
  logic [1:0] cool_s;

  assign raw_in = {pedal_in, door_guard_in, fire_in, spare_in,
                   axis_min_limit, axis_max_limit, coolant_guard_in};

  lmio_sync #(.W(NIN)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign {pedal_s, door_s, fire_s, spare_s, min_s, max_s, cool_s} = syn;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [4:0] ctrl_q;
  logic [15:0] axis_q;
  logic [7:0] duty_q [2];
  logic [1:0] warn_q;
  logic [3:0] home_q;
  lmio_work_t state_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic wr_now;
  logic cmd_wr;
  logic sw_toggle, sw_stop;
  logic [3:0] sw_home;
  logic [3:0] lim_min, lim_max;

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (a)
      REG_CTRL: v[4:0] = ctrl_q;
      REG_AXIS: v[15:0] = axis_q;
      REG_PWM0: v[7:0] = duty_q[0];
      REG_PWM1: v[7:0] = duty_q[1];
      REG_STATUS: begin
        v[ST_STATE +: 3] = state_q;
        v[ST_DOOR] = ctrl_q[CTRL_DOOR_EN] & door_s;
        v[ST_COOL_WARN +: 2] = warn_q;
        v[ST_HOMING +: 4] = home_q;
      end
      REG_INPUTS: begin
        v[IN_LIMIT +: 8] = limit_led;
        v[IN_PEDAL] = ~pedal_s;
        v[IN_SPARE] = spare_s;
        v[IN_FIRE] = ~fire_s;
      end
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction : read_mux

  assign addr_ok = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign wr_now = wr_pend_q;
  assign cmd_wr = wr_now && (wr_addr_q == REG_CMD);
  assign sw_toggle = cmd_wr & hwdata[CMD_START_PAUSE];
  assign sw_stop = cmd_wr & hwdata[CMD_STOP];
  assign sw_home = cmd_wr ? hwdata[CMD_HOME +: 4] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
        rdata_q <= hwrite ? 32'h00000000 : read_mux({haddr[7:2], 2'b00});
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      axis_q <= AXIS_RST;
      duty_q[0] <= PWM_RST;
      duty_q[1] <= PWM_RST;
    end else if (wr_now) begin
      unique case (wr_addr_q)
        REG_CTRL: ctrl_q <= hwdata[4:0];
        REG_AXIS: axis_q <= hwdata[15:0];
        REG_PWM0: duty_q[0] <= hwdata[7:0];
        REG_PWM1: duty_q[1] <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------
  logic door_trip;
  logic [1:0] cool_trip;
  logic protect;

  assign door_trip = ctrl_q[CTRL_DOOR_EN] & door_s;
  assign cool_trip = ctrl_q[CTRL_COOL_EN +: 2] & cool_s;
  assign protect = door_trip | (|cool_trip);

  // Sticky warning, write one to clear, a new trip beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cool_trip[i]) begin
          warn_q[i] <= 1'b1;
        end else if (wr_now && wr_addr_q == REG_STATUS && hwdata[ST_COOL_WARN + i]) begin
          warn_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pedal qualification
  // ----------------------------------------------------------------
  logic pedal_prev_q;
  logic press_start;
  logic pressed;
  logic [CNT_W-1:0] gap_q;
  logic [CNT_W-1:0] hold_q;
  logic press_ok_q;
  logic pedal_ok;

  assign pressed = ~pedal_s;
  assign press_start = pedal_prev_q & ~pedal_s;
  assign pedal_ok = pressed & press_ok_q & (hold_q == CNT_W'(PEDAL_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pedal_prev_q <= 1'b1;
      gap_q <= '1;
      press_ok_q <= 1'b0;
    end else begin
      pedal_prev_q <= pedal_s;
      if (press_start) begin
        press_ok_q <= (gap_q >= CNT_W'(PEDAL_CYCLES));
        gap_q <= '0;
      end else if (gap_q < CNT_W'(PEDAL_CYCLES)) begin
        gap_q <= gap_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q <= '0;
    end else if (!pressed) begin
      hold_q <= '0;
    end else if (hold_q < CNT_W'(PEDAL_CYCLES)) begin
      hold_q <= hold_q + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Work state
  // ----------------------------------------------------------------
  logic toggle;

  assign toggle = pedal_ok | sw_toggle;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= WS_IDLE;
    end else begin
      unique case (state_q)
        WS_IDLE: begin
          if (toggle && !protect) begin
            state_q <= WS_RUN;
          end
        end
        WS_RUN: begin
          if (sw_stop) begin
            state_q <= WS_IDLE;
          end else if (toggle || protect) begin
            state_q <= WS_SUSP;
          end
        end
        WS_SUSP: begin
          if (sw_stop) begin
            state_q <= WS_IDLE;
          end else if (toggle && !protect) begin
            state_q <= WS_RUN;
          end
        end
        default: state_q <= WS_IDLE;
      endcase
    end
  end

  assign work_running = (state_q == WS_RUN);
  assign work_suspended = (state_q == WS_SUSP);

  // ----------------------------------------------------------------
  // Limits and homing
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] home_div_q;
  logic home_tick;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lim_min[i] = min_s[i] ^ axis_q[AXIS_LIM_HIGH + 2*i] ^ 1'b1;
      lim_max[i] = max_s[i] ^ axis_q[AXIS_LIM_HIGH + 2*i + 1] ^ 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limit_led <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        limit_led[2*i] <= lim_min[i];
        limit_led[2*i+1] <= lim_max[i];
      end
    end
  end

  assign home_tick = (home_div_q == CNT_W'(HOME_DIV - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      home_div_q <= '0;
    end else if (home_tick) begin
      home_div_q <= '0;
    end else begin
      home_div_q <= home_div_q + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      home_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (lim_min[i]) begin
          home_q[i] <= 1'b0;
        end else if (sw_home[i] && state_q == WS_IDLE) begin
          home_q[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Step and direction outputs
  // ----------------------------------------------------------------
  logic [PULSE_W-1:0] pulse_q [4];
  logic [3:0] ldir_q;
  logic [3:0] trig;
  logic [3:0] trig_dir;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (home_q[i]) begin
        trig[i] = home_tick & ~lim_min[i];
        trig_dir[i] = 1'b0;
      end else begin
        trig[i] = work_running & step_req[i] & ~(step_dir[i] ? lim_max[i] : lim_min[i]);
        trig_dir[i] = step_dir[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ldir_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        pulse_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pulse_q[i] != '0) begin
          pulse_q[i] <= pulse_q[i] - PULSE_W'(1);
        end else if (trig[i]) begin
          pulse_q[i] <= PULSE_W'(STEP_PULSE_CYC);
          ldir_q[i] <= trig_dir[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      axis_step_out <= 4'hF;
      axis_dir_out <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        axis_step_out[i] <= (pulse_q[i] != '0) ~^ axis_q[AXIS_STEP_RISE + i];
        axis_dir_out[i] <= ldir_q[i] ^ axis_q[AXIS_DIR_INV + i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Laser channels
  // ----------------------------------------------------------------
  logic [1:0] pre_q;
  logic [7:0] pwm_cnt_q;
  logic [1:0] laser_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 2'b00;
      pwm_cnt_q <= 8'h00;
    end else if (pre_q == 2'(PWM_PRESCALE - 1)) begin
      pre_q <= 2'b00;
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end else begin
      pre_q <= pre_q + 2'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      laser_on[i] = ~protect & (~fire_s | (work_running & laser_req[i]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      laser_enable_out_n <= 2'b11;
      laser_power_pwm <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        laser_enable_out_n[i] <= ctrl_q[CTRL_RF + i] | ~laser_on[i];
        laser_power_pwm[i] <= laser_on[i] & (pwm_cnt_q < duty_q[i]);
      end
    end
  end

  assign coolant_warn = warn_q;

endmodule : lmio_top

// ---- hw/lmio_pkg.sv ----
package lmio_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = 20;
  localparam int PEDAL_MIN_MS = 100;
  localparam int PEDAL_CYC = PEDAL_MIN_MS * (CLK_HZ / 1000);
  localparam int HOME_STEP_HZ = 1000;
  localparam int HOME_DIV_CYC = CLK_HZ / HOME_STEP_HZ;
  localparam int STEP_PULSE_NS = 5000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PWM_PRESCALE = 4;
  localparam int CNT_W = 24;
  localparam int PULSE_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AXIS = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_PWM0 = 8'h0C;
  localparam logic [7:0] REG_PWM1 = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_INPUTS = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_DOOR_EN = 0;
  localparam int CTRL_COOL_EN = 1;
  localparam int CTRL_RF = 3;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int AXIS_DIR_INV = 0;
  localparam int AXIS_STEP_RISE = 4;
  localparam int AXIS_LIM_HIGH = 8;
  localparam logic [15:0] AXIS_RST = 16'h0000;
  localparam int CMD_START_PAUSE = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_HOME = 4;
  localparam int ST_STATE = 0;
  localparam int ST_DOOR = 3;
  localparam int ST_COOL_WARN = 4;
  localparam int ST_HOMING = 8;
  localparam int IN_LIMIT = 0;
  localparam int IN_PEDAL = 8;
  localparam int IN_SPARE = 9;
  localparam int IN_FIRE = 10;
  localparam logic [7:0] PWM_RST = 8'h00;

  typedef enum logic [2:0] {
    WS_IDLE = 3'b001,
    WS_RUN = 3'b010,
    WS_SUSP = 3'b100
  } lmio_work_t;

endpackage : lmio_pkg

// ---- hw/lmio_sync.sv ----
`timescale 1ns/1ps
module lmio_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flops; only the second stage leaves this module
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : lmio_sync

// ---- testbench/lmio_props.sv ----
`timescale 1ns/1ps
module lmio_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic fire_in,
  input wire logic [1:0] laser_req,
  input wire logic [1:0] coolant_guard_in,
  input wire logic [3:0] axis_step_out,
  input wire logic [1:0] laser_enable_out_n,
  input wire logic [1:0] laser_power_pwm,
  input wire logic [1:0] coolant_warn,
  input wire logic work_running,
  input wire logic work_suspended
);
  // ----------------------------------------------------------------
  // Age counters for input levels and bus writes
  // ----------------------------------------------------------------
  logic [3:0] quiet_q;
  logic [2:0] cool_q;
  logic [2:0] wr_age_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_q <= 4'h0;
    end else if (!fire_in || laser_req != 2'h0) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cool_q <= 3'h0;
    end else if (!coolant_guard_in[0]) begin
      cool_q <= 3'h0;
    end else if (cool_q != 3'h7) begin
      cool_q <= cool_q + 3'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_age_q <= 3'h7;
    end else if (hsel && htrans[1] && hwrite && hready) begin
      wr_age_q <= 3'h0;
    end else if (wr_age_q != 3'h7) begin
      wr_age_q <= wr_age_q + 3'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  state_excl_a: assert property (!(work_running && work_suspended))
    else $error("running and suspended together");
  step_width_a: assert property ($changed(axis_step_out[0]) |=>
    $stable(axis_step_out[0]) [*8]) else $error("step pulse too short");
  laser_quiet_a: assert property (quiet_q >= 4'h8 |->
    laser_enable_out_n == 2'h3 && laser_power_pwm == 2'h0) else $error("laser on unasked");
  warn_sync_a: assert property ($rose(coolant_warn[0]) |-> cool_q >= 3'h2)
    else $error("coolant warning too early");
  warn_kill_a: assert property ($rose(coolant_warn[0]) |-> ##[0:4]
    (laser_power_pwm == 2'h0 && laser_enable_out_n == 2'h3)) else $error("laser not killed");
  warn_susp_a: assert property ($rose(coolant_warn[0]) |-> ##[0:4] !work_running)
    else $error("work not suspended");
  warn_clear_a: assert property ($fell(coolant_warn[0]) |-> wr_age_q <= 3'h3)
    else $error("warning dropped without write");
  reset_idle_a: assert property ($rose(hresetn) |-> axis_step_out == 4'hF &&
    laser_enable_out_n == 2'h3) else $error("outputs not idle after reset");
  cover property ($rose(work_running));
  cover property ($rose(coolant_warn[0]));
  cover property ($fell(axis_step_out[0]));
endmodule : lmio_props

bind lmio_top lmio_props u_lmio_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .fire_in(fire_in),
  .laser_req(laser_req), .coolant_guard_in(coolant_guard_in),
  .axis_step_out(axis_step_out), .laser_enable_out_n(laser_enable_out_n),
  .laser_power_pwm(laser_power_pwm), .coolant_warn(coolant_warn),
  .work_running(work_running), .work_suspended(work_suspended));

// ---- testbench/lmio_machine_model.sv ----
`timescale 1ns/1ps
module lmio_machine_model #(
  parameter int TRAVEL = 6,
  parameter int START = 2
) (
  input wire logic hclk,
  input wire logic [3:0] axis_step_out,
  input wire logic [3:0] axis_dir_out,
  input wire logic pedal_press,
  input wire logic door_open,
  input wire logic fire_press,
  input wire logic [1:0] cool_fault,
  output logic pedal_in,
  output logic door_guard_in,
  output logic fire_in,
  output logic [1:0] coolant_guard_in,
  output logic [3:0] axis_min_limit,
  output logic [3:0] axis_max_limit
);
  // ----------------------------------------------------------------
  // Switches with pull-ups, axes moved by falling step edges
  // ----------------------------------------------------------------
  int pos [4] = '{START, START, START, START};
  logic [3:0] step_q = 4'hF;
  assign pedal_in = !pedal_press;
  assign door_guard_in = door_open;
  assign fire_in = !fire_press;
  assign coolant_guard_in = cool_fault;
  always @(posedge hclk) begin
    step_q <= axis_step_out;
    for (int i = 0; i < 4; i++) begin
      if (step_q[i] && !axis_step_out[i]) begin
        pos[i] <= axis_dir_out[i] ? pos[i] + 1 : pos[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      axis_min_limit[i] = pos[i] > 0;
      axis_max_limit[i] = pos[i] < TRAVEL;
    end
  end
endmodule : lmio_machine_model

// ---- testbench/test_laser_machine_io_supervisor.sv ----
`timescale 1ns/1ps
module test_laser_machine_io_supervisor;
  import lmio_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
  logic hreadyout, hresp, pedal_in, door_guard_in, fire_in, work_running, work_suspended;
  logic pedal_press = 1'h0, door_open = 1'h0, fire_press = 1'h0, spare_in = 1'h0;
  logic [1:0] cool_fault = 2'h0, laser_req = 2'h0, coolant_guard_in;
  logic [1:0] laser_enable_out_n, laser_power_pwm, coolant_warn;
  logic [3:0] step_req = 4'h0, step_dir = 4'h0, axis_min_limit, axis_max_limit;
  logic [3:0] axis_dir_out, axis_step_out;
  logic [7:0] limit_led;
  int failures = 0, checks_done = 0, cycles = 0, pwm_hi = 0;

  always #25 hclk = ~hclk;

  lmio_top #(.PEDAL_CYCLES(20), .HOME_DIV(16)) u_lmio_top (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .pedal_in, .door_guard_in, .fire_in, .spare_in, .axis_min_limit, .axis_max_limit,
    .coolant_guard_in, .step_req, .step_dir, .laser_req, .axis_dir_out, .axis_step_out,
    .laser_enable_out_n, .laser_power_pwm, .limit_led, .coolant_warn, .work_running,
    .work_suspended);

  lmio_machine_model u_lmio_machine_model (.hclk, .axis_step_out, .axis_dir_out,
    .pedal_press, .door_open, .fire_press, .cool_fault, .pedal_in, .door_guard_in,
    .fire_in, .coolant_guard_in, .axis_min_limit, .axis_max_limit);

  // ----------------------------------------------------------------
  // Bus, timing and comparison tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'h1, d, st);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'h0, 32'h0, st);
    check(st, exp);
  endtask : rc

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc

  task automatic press(input int n);
    @(posedge hclk);
    pedal_press <= 1'h1;
    cyc(n);
    pedal_press <= 1'h0;
  endtask : press

  task automatic wait_step(input int n);
    for (int i = 0; i < n && axis_step_out[0] !== 1'h0; i++) cyc(1);
  endtask : wait_step

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    cyc(1);
    check(axis_step_out, 4'hF);
    check(laser_enable_out_n, 2'h3);
    rc(REG_STATUS, 32'h1);
    rc(REG_AXIS, 32'h0);
    rc(8'h3C, 32'h0);
    check(hresp, 1'h0);
    spare_in <= 1'h1;
    wr(REG_CMD, 32'h10);
    cyc(20);
    check(axis_dir_out[0], 1'h0);
    st = 32'h100;
    for (int i = 0; i < 300 && st[8]; i++) bus(REG_STATUS, 1'h0, 32'h0, st);
    check(st, 32'h1);
    check(limit_led[1:0], 2'h1);
    rc(REG_INPUTS, 32'h201);
    wr(REG_AXIS, 32'h300);
    cyc(4);
    check(limit_led[1:0], 2'h2);
    wr(REG_AXIS, 32'h0);
    press(10);
    cyc(3);
    press(40);
    rc(REG_STATUS, 32'h1);
    cyc(30);
    press(30);
    rc(REG_STATUS, 32'h2);
    press(30);
    rc(REG_STATUS, 32'h4);
    press(30);
    rc(REG_STATUS, 32'h2);
    step_req <= 4'h1;
    cyc(12);
    check(axis_step_out[0], 1'h1);
    step_dir <= 4'h1;
    wait_step(12);
    step_req <= 4'h0;
    check(axis_step_out[0], 1'h0);
    check(axis_dir_out[0], 1'h1);
    cyc(120);
    wr(REG_AXIS, 32'h1);
    step_req <= 4'h1;
    wait_step(20);
    step_req <= 4'h0;
    check(axis_dir_out[0], 1'h0);
    laser_req <= 2'h2;
    fire_press <= 1'h1;
    wr(REG_PWM0, 32'h80);
    cyc(1030);
    check(laser_enable_out_n, 2'h0);
    for (int i = 0; i < 1024; i++) begin
      cyc(1);
      pwm_hi += (laser_power_pwm[0] === 1'h1);
    end
    check(pwm_hi, 512);
    wr(REG_CTRL, 32'h08);
    door_open <= 1'h1;
    cyc(8);
    check(laser_enable_out_n, 2'h1);
    check(work_running, 1'h1);
    wr(REG_CTRL, 32'h10);
    cyc(8);
    check(laser_enable_out_n, 2'h2);
    wr(REG_CTRL, 32'h09);
    cyc(8);
    check({laser_power_pwm, laser_enable_out_n}, 4'h3);
    check(work_suspended, 1'h1);
    press(30);
    rc(REG_STATUS, 32'hC);
    door_open <= 1'h0;
    wr(REG_CTRL, 32'h02);
    press(30);
    rc(REG_STATUS, 32'h2);
    cool_fault <= 2'h2;
    cyc(8);
    check({coolant_warn, work_running}, 3'h1);
    cool_fault <= 2'h3;
    cyc(8);
    check({coolant_warn, laser_power_pwm}, 4'h4);
    rc(REG_STATUS, 32'h14);
    cool_fault <= 2'h0;
    wr(REG_STATUS, 32'h10);
    rc(REG_STATUS, 32'h4);
    wr(REG_CMD, 32'h2);
    rc(REG_STATUS, 32'h1);
    laser_req <= 2'h0;
    fire_press <= 1'h0;
    wr(REG_AXIS, 32'h80);
    cyc(4);
    check(axis_step_out, 4'h7);
    end_sim();
  end
endmodule : test_laser_machine_io_supervisor
